// ---- inc/zone_cmd_pkg.sv ----
// Package with register offsets, codes and reset values of the zone command interpreter.
package zone_cmd_pkg;
  localparam logic [9:0] OFF_STOP_GROUP = 10'h014;
  localparam logic [9:0] OFF_UP_JAM = 10'h06d;
  localparam logic [9:0] OFF_DN_JAM = 10'h0bd;
  localparam logic [9:0] OFF_UP_DIR = 10'h16d;
  localparam logic [9:0] OFF_DN_DIR = 10'h177;
  localparam logic [9:0] OFF_MERGE = 10'h183;
  localparam logic [9:0] OFF_UP_TRK1 = 10'h190;
  localparam logic [9:0] OFF_UP_TRK2 = 10'h191;
  localparam logic [9:0] OFF_DN_TRK1 = 10'h192;
  localparam logic [9:0] OFF_DN_TRK2 = 10'h193;
  localparam logic [9:0] OFF_UP_SPEED = 10'h194;
  localparam logic [9:0] OFF_DN_SPEED = 10'h195;
  localparam logic [15:0] STOP_NONE = 16'h0000;
  localparam logic [15:0] STOP_SET = 16'h0001;
  localparam logic [15:0] STOP_CLEAR = 16'h0002;
  localparam logic [7:0] DA_NORMAL = 8'h00;
  localparam logic [7:0] DA_ACCUM_A = 8'h01;
  localparam logic [7:0] DA_ACCUM_B = 8'h02;
  localparam logic [7:0] DA_REL_CHANGE = 8'h03;
  localparam logic [7:0] DA_REL_DEFAULT = 8'h04;
  localparam logic [7:0] DA_FORWARD = 8'h0a;
  localparam logic [7:0] DA_REVERSE = 8'h0b;
  localparam logic [7:0] DA_MAX_ZONES = 8'hdc;
  localparam int MERGE_EN_BIT = 15;
  localparam int MERGE_INH_LSB = 4;
  localparam int MERGE_PRIO_LSB = 0;
  localparam logic [15:0] TRK_CLEAR = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  localparam logic [2:0] INH_RESET = 3'h0;
endpackage : zone_cmd_pkg

// ---- design/zone_command_word_interface.sv ----
// Command-word interpreter for a two-zone conveyor module, fed by a cyclic output image.
// Functional notes
// (R1) Stop word: 0 none, 1 stop, 2 clear.
// (R2) Upstream jam clear on rising 0 to 1.
// (R3) Downstream jam clear on rising 0 to 1.
// (R4) Low byte 0..4: normal, accumulate, release modes.
// (R5) Low byte 10 forward, 11 reverse.
// (R6) High byte zone count; zero means all zones.
// (R7) Merge word acts only with bit 15.
// (R8) Bits 4..6 inhibit center, left, right.
// (R9) Bits 0..3 select release priority.
// (R10) Tracking holding copied to live on release.
// (R11) Both holding zero keeps live tracking.
// (R12) Both holding 0xffff clears live tracking.
// (R13) Single 0xffff word is taken literally.
// (R14) Zero speed means configured speed.
// (R15) Speed clamped to motor limits.
// (R16) Zero after non-zero keeps last speed.
// (R17) Downstream direction word uses same encoding.
// (R18) Only value changes or edges trigger commands.
module zone_command_word_interface #(
  parameter int WORD_W = 16,
  parameter int ADDR_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [WORD_W-1:0] wr_data_i,
  input wire logic up_release_i,
  input wire logic dn_release_i,
  input wire logic [WORD_W-1:0] speed_min_i,
  input wire logic [WORD_W-1:0] speed_max_i,
  output logic stop_group_stopped_o,
  output logic up_jam_clear_o,
  output logic dn_jam_clear_o,
  output logic up_da_valid_o,
  output logic [7:0] up_da_action_o,
  output logic [7:0] up_da_zones_o,
  output logic up_da_all_o,
  output logic dn_da_valid_o,
  output logic [7:0] dn_da_action_o,
  output logic [7:0] dn_da_zones_o,
  output logic dn_da_all_o,
  output logic [2:0] merge_inhibit_o,
  output logic [3:0] merge_priority_o,
  output logic [WORD_W-1:0] up_trk1_o,
  output logic [WORD_W-1:0] up_trk2_o,
  output logic [WORD_W-1:0] dn_trk1_o,
  output logic [WORD_W-1:0] dn_trk2_o,
  output logic up_speed_override_o,
  output logic [WORD_W-1:0] up_speed_o,
  output logic dn_speed_override_o,
  output logic [WORD_W-1:0] dn_speed_o
);

  // Slices and offsets below assume a 16-bit word and at least 10 address bits.
  if (WORD_W != 16 || ADDR_W < 10) begin : g_bad_params
    $error("zone_command_word_interface: WORD_W must be 16 and ADDR_W at least 10");
  end

  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  function automatic logic [WORD_W-1:0] clamp(input logic [WORD_W-1:0] v,
                                                input logic [WORD_W-1:0] lo,
                                                input logic [WORD_W-1:0] hi);
    if (v > hi) begin
      clamp = hi;
    end else if (v < lo) begin
      clamp = lo;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  function automatic logic da_legal(input logic [7:0] code);
    da_legal = (code == zone_cmd_pkg::DA_NORMAL) || (code == zone_cmd_pkg::DA_ACCUM_A) ||
               (code == zone_cmd_pkg::DA_ACCUM_B) || (code == zone_cmd_pkg::DA_REL_CHANGE) ||
               (code == zone_cmd_pkg::DA_REL_DEFAULT) || (code == zone_cmd_pkg::DA_FORWARD) ||
               (code == zone_cmd_pkg::DA_REVERSE);
  endfunction : da_legal

  // Register image as last written by the controller.
  logic [WORD_W-1:0] stop_word_q;
  logic [WORD_W-1:0] up_jam_q;
  logic [WORD_W-1:0] dn_jam_q;
  logic [WORD_W-1:0] up_da_q;
  logic [WORD_W-1:0] dn_da_q;
  logic [WORD_W-1:0] up_hold1_q;
  logic [WORD_W-1:0] up_hold2_q;
  logic [WORD_W-1:0] dn_hold1_q;
  logic [WORD_W-1:0] dn_hold2_q;

  logic wr_stop;
  logic wr_up_jam;
  logic wr_dn_jam;
  logic wr_up_da;
  logic wr_dn_da;
  logic wr_merge;
  logic wr_up_spd;
  logic wr_dn_spd;
  logic wr_up_trk1;
  logic wr_up_trk2;
  logic wr_dn_trk1;
  logic wr_dn_trk2;

  assign wr_stop = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_STOP_GROUP);
  assign wr_up_jam = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_UP_JAM);
  assign wr_dn_jam = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_DN_JAM);
  assign wr_up_da = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_UP_DIR);
  assign wr_dn_da = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_DN_DIR);
  assign wr_merge = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_MERGE);
  assign wr_up_spd = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_UP_SPEED);
  assign wr_dn_spd = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_DN_SPEED);
  assign wr_up_trk1 = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_UP_TRK1);
  assign wr_up_trk2 = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_UP_TRK2);
  assign wr_dn_trk1 = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_DN_TRK1);
  assign wr_dn_trk2 = wr_en_i && hit(wr_addr_i, zone_cmd_pkg::OFF_DN_TRK2);

  // Each stored word keeps the last written value for change and edge detection.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stop_word_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_stop) begin
      stop_word_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_jam_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_up_jam) begin
      up_jam_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_jam_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_dn_jam) begin
      dn_jam_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_da_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_up_da) begin
      up_da_q <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_da_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_dn_da) begin
      dn_da_q <= wr_data_i;
    end
  end

  // Holding words only; the live copies move on release, so cyclic rewrites are harmless.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_hold1_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_up_trk1) begin
      up_hold1_q <= wr_data_i; // R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_hold2_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_up_trk2) begin
      up_hold2_q <= wr_data_i; // R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_hold1_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_dn_trk1) begin
      dn_hold1_q <= wr_data_i; // R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_hold2_q <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_dn_trk2) begin
      dn_hold2_q <= wr_data_i; // R10
    end
  end

  // Stop group: a rewritten command that is unchanged does nothing new.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stop_group_stopped_o <= 1'b0;
    end else if (wr_stop && wr_data_i != stop_word_q) begin // R18
      if (wr_data_i == zone_cmd_pkg::STOP_SET) begin
        stop_group_stopped_o <= 1'b1; // R1
      end else if (wr_data_i == zone_cmd_pkg::STOP_CLEAR) begin
        stop_group_stopped_o <= 1'b0; // R1
      end
    end
  end

  // Jam clear pulses on a 0 to 1 change of the word only.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_jam_clear_o <= 1'b0;
    end else begin
      up_jam_clear_o <= wr_up_jam && up_jam_q == 16'h0000 && wr_data_i == 16'h0001; // R2 R18
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_jam_clear_o <= 1'b0;
    end else begin
      dn_jam_clear_o <= wr_dn_jam && dn_jam_q == 16'h0000 && wr_data_i == 16'h0001; // R3 R18
    end
  end

  // Direction and accumulation commands issue one pulse per changed legal word.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_da_valid_o <= 1'b0;
      up_da_action_o <= zone_cmd_pkg::DA_NORMAL;
      up_da_zones_o <= 8'h00;
      up_da_all_o <= 1'b0;
    end else begin
      up_da_valid_o <= 1'b0;
      if (wr_up_da && wr_data_i != up_da_q && da_legal(wr_data_i[7:0]) && // R18
          wr_data_i[15:8] <= zone_cmd_pkg::DA_MAX_ZONES) begin
        up_da_valid_o <= 1'b1; // R4 R5
        up_da_action_o <= wr_data_i[7:0]; // R4 R5
        up_da_zones_o <= wr_data_i[15:8]; // R6
        up_da_all_o <= (wr_data_i[15:8] == 8'h00); // R6
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_da_valid_o <= 1'b0;
      dn_da_action_o <= zone_cmd_pkg::DA_NORMAL;
      dn_da_zones_o <= 8'h00;
      dn_da_all_o <= 1'b0;
    end else begin
      dn_da_valid_o <= 1'b0;
      if (wr_dn_da && wr_data_i != dn_da_q && da_legal(wr_data_i[7:0]) && // R18
          wr_data_i[15:8] <= zone_cmd_pkg::DA_MAX_ZONES) begin
        dn_da_valid_o <= 1'b1; // R17
        dn_da_action_o <= wr_data_i[7:0]; // R17
        dn_da_zones_o <= wr_data_i[15:8]; // R17
        dn_da_all_o <= (wr_data_i[15:8] == 8'h00); // R17
      end
    end
  end

  // Merge configuration is only touched with the enable bit set.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      merge_inhibit_o <= zone_cmd_pkg::INH_RESET;
      merge_priority_o <= zone_cmd_pkg::PRIO_RESET;
    end else if (wr_merge && wr_data_i[zone_cmd_pkg::MERGE_EN_BIT]) begin // R7
      merge_inhibit_o <= wr_data_i[zone_cmd_pkg::MERGE_INH_LSB +: 3]; // R8
      // A priority code above 3 is ignored while the inhibit bits still apply.
      if (wr_data_i[zone_cmd_pkg::MERGE_PRIO_LSB +: 4] <= 4'h3) begin
        merge_priority_o <= wr_data_i[zone_cmd_pkg::MERGE_PRIO_LSB +: 4]; // R9
      end
    end
  end

  // Live tracking words load from the holding words on release.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_trk1_o <= zone_cmd_pkg::WORD_ZERO;
      up_trk2_o <= zone_cmd_pkg::WORD_ZERO;
    end else if (up_release_i) begin // R10
      if (up_hold1_q == zone_cmd_pkg::TRK_CLEAR && up_hold2_q == zone_cmd_pkg::TRK_CLEAR) begin
        up_trk1_o <= zone_cmd_pkg::WORD_ZERO; // R12
        up_trk2_o <= zone_cmd_pkg::WORD_ZERO; // R12
      end else if (!(up_hold1_q == zone_cmd_pkg::WORD_ZERO &&
                     up_hold2_q == zone_cmd_pkg::WORD_ZERO)) begin // R11
        up_trk1_o <= up_hold1_q; // R13
        up_trk2_o <= up_hold2_q; // R13
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_trk1_o <= zone_cmd_pkg::WORD_ZERO;
      dn_trk2_o <= zone_cmd_pkg::WORD_ZERO;
    end else if (dn_release_i) begin // R10
      if (dn_hold1_q == zone_cmd_pkg::TRK_CLEAR && dn_hold2_q == zone_cmd_pkg::TRK_CLEAR) begin
        dn_trk1_o <= zone_cmd_pkg::WORD_ZERO; // R12
        dn_trk2_o <= zone_cmd_pkg::WORD_ZERO; // R12
      end else if (!(dn_hold1_q == zone_cmd_pkg::WORD_ZERO &&
                     dn_hold2_q == zone_cmd_pkg::WORD_ZERO)) begin // R11
        dn_trk1_o <= dn_hold1_q; // R13
        dn_trk2_o <= dn_hold2_q; // R13
      end
    end
  end

  // Speed reference: a zero write keeps the last non-zero reference.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      up_speed_override_o <= 1'b0; // R14
      up_speed_o <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_up_spd && wr_data_i != zone_cmd_pkg::WORD_ZERO) begin // R16
      up_speed_override_o <= 1'b1; // R14
      up_speed_o <= clamp(wr_data_i, speed_min_i, speed_max_i); // R15
    end
  end

  // The downstream reference shares the motor limits with the upstream one.
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dn_speed_override_o <= 1'b0; // R14
      dn_speed_o <= zone_cmd_pkg::WORD_ZERO;
    end else if (wr_dn_spd && wr_data_i != zone_cmd_pkg::WORD_ZERO) begin // R16
      dn_speed_override_o <= 1'b1; // R14
      dn_speed_o <= clamp(wr_data_i, speed_min_i, speed_max_i); // R15
    end
  end

endmodule : zone_command_word_interface

// ---- test/zone_cmd_monitor.sv ----
// Port checker for the zone command interpreter.
module zone_cmd_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [9:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic up_release_i,
  input wire logic stop_group_stopped_o,
  input wire logic up_jam_clear_o,
  input wire logic dn_jam_clear_o,
  input wire logic [2:0] merge_inhibit_o,
  input wire logic [3:0] merge_priority_o,
  input wire logic [15:0] up_trk1_o,
  input wire logic [15:0] up_speed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_wr(logic [9:0] a, logic [15:0] d);
    wr_en_i && wr_addr_i == a && wr_data_i == d;
  endsequence
  sequence s_merge(logic en);
    wr_en_i && wr_addr_i == zone_cmd_pkg::OFF_MERGE && wr_data_i[15] == en;
  endsequence
  a_up_jam_edge: assert property (up_jam_clear_o |-> $past(wr_en_i && wr_data_i == 16'h0001
    && wr_addr_i == zone_cmd_pkg::OFF_UP_JAM)) else $error("upstream clear without write");
  a_dn_jam_edge: assert property (dn_jam_clear_o |-> $past(wr_en_i && wr_data_i == 16'h0001
    && wr_addr_i == zone_cmd_pkg::OFF_DN_JAM)) else $error("downstream clear without write");
  a_stop_set: assert property (s_wr(zone_cmd_pkg::OFF_STOP_GROUP, zone_cmd_pkg::STOP_SET)
    |=> stop_group_stopped_o) else $error("stop group not stopped");
  a_stop_clear: assert property (s_wr(zone_cmd_pkg::OFF_STOP_GROUP, zone_cmd_pkg::STOP_CLEAR)
    |=> !stop_group_stopped_o) else $error("stop group not cleared");
  a_merge_locked: assert property (s_merge(1'b0)
    |=> $stable(merge_inhibit_o) && $stable(merge_priority_o)) else $error("merge changed");
  a_merge_inhibit: assert property (s_merge(1'b1)
    |=> merge_inhibit_o == $past(wr_data_i[6:4])) else $error("inhibit bits wrong");
  a_trk_on_release: assert property ($changed(up_trk1_o) |-> $past(up_release_i))
    else $error("tracking changed without release");
  a_speed_kept: assert property (s_wr(zone_cmd_pkg::OFF_UP_SPEED, zone_cmd_pkg::WORD_ZERO)
    |=> $stable(up_speed_o)) else $error("speed changed on zero");
endmodule : zone_cmd_monitor

bind zone_command_word_interface zone_cmd_monitor u_zone_cmd_monitor (.clk_i, .rst_n_i,
  .wr_en_i, .wr_addr_i, .wr_data_i, .up_release_i, .stop_group_stopped_o, .up_jam_clear_o,
  .dn_jam_clear_o, .merge_inhibit_o, .merge_priority_o, .up_trk1_o, .up_speed_o);

// ---- test/plc_image_model.sv ----
// Controller model that writes output image words, one word per call.
module plc_image_model (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic [9:0] wr_addr_o,
  output logic [15:0] wr_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 10'h000;
    wr_data_o = 16'h0000;
  end
  // Released lines show the inverse so that stale values are never taken as live.
  task automatic put(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
    @(posedge clk_i);
  endtask : put
endmodule : plc_image_model

// ---- test/testbench.sv ----
// Self-checking bench for the zone command interpreter.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, wr_en_i, up_release_i, dn_release_i, look;
  logic [9:0] wr_addr_i;
  logic [15:0] wr_data_i, speed_min_i, speed_max_i, up_trk1_o, up_trk2_o, dn_trk1_o, dn_trk2_o;
  logic [15:0] up_speed_o, dn_speed_o;
  logic stop_group_stopped_o, up_jam_clear_o, dn_jam_clear_o, up_da_valid_o, dn_da_valid_o;
  logic up_da_all_o, dn_da_all_o, up_speed_override_o, dn_speed_override_o;
  logic [7:0] up_da_action_o, up_da_zones_o, dn_da_action_o, dn_da_zones_o;
  logic [2:0] merge_inhibit_o;
  logic [3:0] merge_priority_o;
  logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b};
  logic [35:0] notes [$];
  logic [35:0] head;
  int errors = 0;
  int total_checks = 0;
  int seed = 41626;
  zone_command_word_interface u_zone_command_word_interface (.clk_i, .rst_n_i, .wr_en_i,
    .wr_addr_i, .wr_data_i, .up_release_i, .dn_release_i, .speed_min_i, .speed_max_i,
    .stop_group_stopped_o, .up_jam_clear_o, .dn_jam_clear_o, .up_da_valid_o, .up_da_action_o,
    .up_da_zones_o, .up_da_all_o, .dn_da_valid_o, .dn_da_action_o, .dn_da_zones_o, .dn_da_all_o,
    .merge_inhibit_o, .merge_priority_o, .up_trk1_o, .up_trk2_o, .dn_trk1_o, .dn_trk2_o,
    .up_speed_override_o, .up_speed_o, .dn_speed_override_o, .dn_speed_o);
  plc_image_model u_plc_image_model (.clk_i, .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i));
  function automatic logic [31:0] obs(input logic [3:0] s);
    case (s)
      4'h1: obs = {14'h0, up_da_valid_o, up_da_all_o, up_da_zones_o, up_da_action_o};
      4'h2: obs = {14'h0, dn_da_valid_o, dn_da_all_o, dn_da_zones_o, dn_da_action_o};
      4'h3: obs = {30'h0, up_jam_clear_o, dn_jam_clear_o};
      4'h4: obs = {31'h0, stop_group_stopped_o};
      4'h5: obs = {25'h0, merge_inhibit_o, merge_priority_o};
      4'h6: obs = {up_trk1_o, up_trk2_o};
      4'h7: obs = {dn_trk1_o, dn_trk2_o};
      4'h8: obs = {15'h0, up_speed_override_o, up_speed_o};
      default: obs = {15'h0, dn_speed_override_o, dn_speed_o};
    endcase
  endfunction : obs
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    u_plc_image_model.put(a, d);
  endtask : wr
  task automatic chk(input logic [3:0] s, input logic [31:0] e);
    notes.push_back({s, e});
    look = 1'b1;
    @(negedge clk_i);
    look <= 1'b0;
    @(posedge clk_i);
  endtask : chk
  task automatic rel(input int z);
    @(negedge clk_i);
    up_release_i = (z == 0);
    dn_release_i = (z == 1);
    @(negedge clk_i);
    up_release_i = 1'b0;
    dn_release_i = 1'b0;
    @(posedge clk_i);
  endtask : rel
  // Every pulse or requested look consumes the oldest expectation.
  always @(negedge clk_i) begin
    if (up_jam_clear_o | dn_jam_clear_o | up_da_valid_o | dn_da_valid_o | look) begin
      if (notes.size() == 0) begin
        cmp(32'h1, 32'h0);
      end else begin
        head = notes.pop_front();
        cmp(obs(head[35:32]), head[31:0]);
      end
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #1000000;
    errors++;
    conclude();
  end
  initial begin
    logic [7:0] hb;
    logic [15:0] v;
    logic [31:0] hold, live;
    logic [9:0] a;
    {rst_n_i, up_release_i, dn_release_i, look} = 4'h0;
    speed_min_i = 16'h0064;
    speed_max_i = 16'h03e8;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    chk(4'h8, 32'h0);
    chk(4'h9, 32'h0);
    wr(zone_cmd_pkg::OFF_STOP_GROUP, zone_cmd_pkg::STOP_SET);
    chk(4'h4, 32'h1);
    wr(zone_cmd_pkg::OFF_STOP_GROUP, zone_cmd_pkg::STOP_NONE);
    chk(4'h4, 32'h1);
    wr(zone_cmd_pkg::OFF_STOP_GROUP, zone_cmd_pkg::STOP_CLEAR);
    chk(4'h4, 32'h0);
    for (int z = 0; z < 2; z++) begin
      a = z ? zone_cmd_pkg::OFF_DN_JAM : zone_cmd_pkg::OFF_UP_JAM;
      notes.push_back({4'h3, z ? 32'h1 : 32'h2});
      wr(a, 16'h0001);
      wr(a, 16'h0001);
      wr(a, 16'h0000);
      notes.push_back({4'h3, z ? 32'h1 : 32'h2});
      wr(a, 16'h0001);
    end
    for (int j = 0; j < 14; j++) begin
      hb = (j / 2 == 1) ? 8'h00 : (j / 2 == 6) ? zone_cmd_pkg::DA_MAX_ZONES :
        8'(1 + $unsigned($random(seed)) % 219);
      notes.push_back({4'(1 + j % 2), 14'h0, 1'b1, hb == 8'h00, hb, codes[j / 2]});
      v = {hb, codes[j / 2]};
      wr((j % 2) ? zone_cmd_pkg::OFF_DN_DIR : zone_cmd_pkg::OFF_UP_DIR, v);
      wr((j % 2) ? zone_cmd_pkg::OFF_DN_DIR : zone_cmd_pkg::OFF_UP_DIR, v);
    end
    wr(zone_cmd_pkg::OFF_UP_DIR, 16'h0005);
    wr(zone_cmd_pkg::OFF_UP_DIR, 16'hdd0a);
    chk(4'h1, 32'h0000dc0b);
    wr(zone_cmd_pkg::OFF_MERGE, 16'h0072);
    chk(4'h5, 32'h0);
    for (int j = 0; j < 4; j++) begin
      wr(zone_cmd_pkg::OFF_MERGE, 16'h8000 | 16'((j + 4) << 4) | 16'(j));
      chk(4'h5, 32'((j + 4) << 4 | j));
    end
    wr(zone_cmd_pkg::OFF_MERGE, 16'h8015);
    chk(4'h5, 32'h13);
    for (int z = 0; z < 2; z++) begin
      live = 32'h0;
      for (int k = 0; k < 4; k++) begin
        hold = (k == 0) ? ($random(seed) | 32'h00010001) : (k == 1) ? 32'h0 :
          (k == 2) ? 32'hffff1234 : 32'hffffffff;
        wr(z ? zone_cmd_pkg::OFF_DN_TRK1 : zone_cmd_pkg::OFF_UP_TRK1, hold[31:16]);
        wr(z ? zone_cmd_pkg::OFF_DN_TRK2 : zone_cmd_pkg::OFF_UP_TRK2, hold[15:0]);
        chk(4'(6 + z), live);
        live = (k == 1) ? live : (k == 3) ? 32'h0 : hold;
        rel(z);
        chk(4'(6 + z), live);
      end
    end
    for (int z = 0; z < 2; z++) begin
      a = z ? zone_cmd_pkg::OFF_DN_SPEED : zone_cmd_pkg::OFF_UP_SPEED;
      v = 16'(100 + $unsigned($random(seed)) % 901);
      wr(a, v);
      chk(4'(8 + z), {15'h0, 1'b1, v});
      wr(a, 16'h0005);
      chk(4'(8 + z), 32'h00010064);
      wr(a, 16'h0000);
      chk(4'(8 + z), 32'h00010064);
      wr(a, 16'h1388);
      chk(4'(8 + z), 32'h000103e8);
    end
    cmp(32'(notes.size()), 32'h0);
    conclude();
  end
endmodule : testbench
